// >>> src/ltsm_top.sv
//------------------------------------------------------------------------------
// Purpose: lamp open-circuit test and diagnostic status reporting
// Assumes: fault inputs are active high, lamp sense from pins is asynchronous
// Notes: status outputs use 1 = normal, 0 = fault
//------------------------------------------------------------------------------
// How it works
// RQ1: lamp test runs once every 3 seconds per lamp output.
// RQ2: two failed tests in a row declare a burned lamp.
// RQ3: first test waits for the next 3 s boundary after switch-on.
// RQ4: test repeats each interval while the output stays commanded on.
// RQ5: burned lamp reported within 6 s of command on.
// RQ6: controller keeps the lamp output on at least 6 s.
// RQ7: status reads 1 after reset while output stays off.
// RQ8: an already open lamp is found only after command on.
// RQ9: replacing the lamp restores status to normal, any command.
// RQ10: lamp status 1 when intact, 0 once open declared.
// RQ11: only the controller drives lamp outputs, never the status.
// RQ12: every status bit: 1 normal or on, 0 fault.
// RQ13: one status bit per input, output and test output.
// RQ14: controller forces its status copy off on lost connection.
// RQ15: combined statuses are the AND of all point statuses.
// RQ16: output monitor reflects actual output state.
// RQ17: one status bit per analog channel, 1 when normal.
// RQ18: flag supply, sensor power, signal range; broken wire only in current mode.
// RQ19: measurement disagreement clears channel status and zeroes its value.
// RQ20: per-channel alarm word holds limit and tachometer flags.
// RQ21: failure count clears on a pass or when output goes off.
`timescale 1ns/1ps
module ltsm_top
  import ltsm_pkg::*;
#(
  parameter int unsigned N_IN = 8,
  parameter int unsigned N_OUT = 8,
  parameter int unsigned N_TEST = 4,
  parameter int unsigned N_AIN = 4,
  parameter int unsigned AW = 16,
  parameter longint unsigned INTERVAL_CYC = LAMP_INTERVAL_CYC
)
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic lamp_test_output_a_cmd_i,
  input wire logic lamp_test_output_b_cmd_i,
  input wire logic lamp_a_sense_ok_i,
  input wire logic lamp_b_sense_ok_i,
  output logic lamp_test_output_a_o,
  output logic lamp_test_output_b_o,
  output logic lamp_a_status_o,
  output logic lamp_b_status_o,
  input wire logic [N_IN-1:0] in_fault_i,
  input wire logic [N_OUT-1:0] out_fault_i,
  input wire logic [N_TEST-1:0] test_fault_i,
  input wire logic [N_OUT-1:0] out_actual_i,
  output logic [N_IN-1:0] in_status_o,
  output logic [N_OUT-1:0] out_status_o,
  output logic [N_TEST-1:0] test_status_o,
  output logic in_combined_o,
  output logic out_combined_o,
  output logic [N_OUT-1:0] out_monitor_o,
  input wire logic supply_range_fault_i,
  input wire logic [N_AIN-1:0] sensor_pwr_fault_i,
  input wire logic [N_AIN-1:0] signal_range_fault_i,
  input wire logic [N_AIN-1:0] current_mode_i,
  input wire logic [N_AIN-1:0] wire_open_i,
  input wire logic [N_AIN-1:0][AW-1:0] meas_a_i,
  input wire logic [N_AIN-1:0][AW-1:0] meas_b_i,
  input wire logic [AW-1:0] meas_tol_i,
  input wire logic [N_AIN-1:0][ALM_W-1:0] alarm_raw_i,
  output logic supply_fault_o,
  output logic [N_AIN-1:0] sensor_pwr_fault_o,
  output logic [N_AIN-1:0] signal_range_fault_o,
  output logic [N_AIN-1:0] wire_broken_o,
  output logic [N_AIN-1:0] meas_mismatch_o,
  output logic [N_AIN-1:0] ain_status_o,
  output logic [N_AIN-1:0][AW-1:0] ain_value_o,
  output logic [N_AIN-1:0][ALM_W-1:0] alarm_status_o
);

  // ----------------------------------------------------------------
  // interval tick: free running, so switch-on aligns to next boundary
  // ----------------------------------------------------------------
  logic [39:0] tick_cnt;
  logic [39:0] next_tick_cnt;
  logic tick;
  logic next_tick;

  always_comb
  begin
    next_tick = 1'b0;
    next_tick_cnt = tick_cnt + 40'h1;
    if (tick_cnt >= 40'(INTERVAL_CYC - 1))
    begin
      next_tick_cnt = '0;
      next_tick = 1'b1; // RQ1 RQ3
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      tick_cnt <= '0;
      tick <= 1'b0;
    end
    else
    begin
      tick_cnt <= next_tick_cnt;
      tick <= next_tick;
    end
  end

  // ----------------------------------------------------------------
  // lamp sense pins: three-stage sync, change counts when 2 and 3 agree
  // ----------------------------------------------------------------
  logic [1:0] sense_s1;
  logic [1:0] sense_s2;
  logic [1:0] sense_s3;
  logic [1:0] sense_ok;
  logic [1:0] next_sense_ok;

  always_comb
  begin
    next_sense_ok = sense_ok;
    for (int i = 0; i < 2; i++)
      if (sense_s2[i] == sense_s3[i])
        next_sense_ok[i] = sense_s3[i];
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      sense_s1 <= 2'h3;
      sense_s2 <= 2'h3;
      sense_s3 <= 2'h3;
      sense_ok <= 2'h3;
    end
    else
    begin
      sense_s1 <= {lamp_b_sense_ok_i, lamp_a_sense_ok_i};
      sense_s2 <= sense_s1;
      sense_s3 <= sense_s2;
      sense_ok <= next_sense_ok;
    end
  end

  // ----------------------------------------------------------------
  // lamp checkers, one per lamp test output
  // ----------------------------------------------------------------
  logic [1:0] lamp_cmd;
  logic [1:0] lamp_stat;
  assign lamp_cmd = {lamp_test_output_b_cmd_i, lamp_test_output_a_cmd_i};

  for (genvar g = 0; g < 2; g++)
  begin : g_lamp
    ltsm_lamp_if lif();
    assign lif.tick = tick;
    assign lif.cmd_on = lamp_cmd[g];
    assign lif.lamp_ok = sense_ok[g];
    assign lamp_stat[g] = lif.status;
    ltsm_lamp_check u_chk (
      .ref_clk_i(ref_clk_i),
      .rst_i(rst_i),
      .lamp(lif.checker_side)
    );
  end

  // ----------------------------------------------------------------
  // digital status: per point and combined
  // ----------------------------------------------------------------
  logic [N_IN-1:0] next_in_status;
  logic [N_OUT-1:0] next_out_status;
  logic [N_TEST-1:0] next_test_status;
  logic next_in_comb;
  logic next_out_comb;

  always_comb
  begin
    next_in_status = ~in_fault_i; // RQ12 RQ13
    next_out_status = ~out_fault_i; // RQ13
    next_test_status = ~test_fault_i; // RQ13
    next_in_comb = &next_in_status; // RQ15
    next_out_comb = &next_out_status; // RQ15
  end

  // ----------------------------------------------------------------
  // analog status: flags, mismatch check and value gating
  // ----------------------------------------------------------------
  logic [N_AIN-1:0] next_wire;
  logic [N_AIN-1:0] next_mis;
  logic [N_AIN-1:0] next_ain_stat;
  logic [N_AIN-1:0][AW-1:0] next_ain_val;
  logic [AW-1:0] diff;

  always_comb
  begin
    diff = '0;
    for (int c = 0; c < N_AIN; c++)
    begin
      diff = (meas_a_i[c] > meas_b_i[c]) ? meas_a_i[c] - meas_b_i[c]
                                         : meas_b_i[c] - meas_a_i[c];
      next_mis[c] = diff > meas_tol_i; // RQ19
      next_wire[c] = wire_open_i[c] & current_mode_i[c]; // RQ18
      next_ain_stat[c] = ~(next_mis[c] | next_wire[c] | sensor_pwr_fault_i[c]
                          | signal_range_fault_i[c] | supply_range_fault_i); // RQ17
      next_ain_val[c] = next_mis[c] ? '0 : meas_a_i[c]; // RQ19
    end
  end

  // ----------------------------------------------------------------
  // output registers: every output straight from a flip-flop
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      lamp_test_output_a_o <= 1'b0;
      lamp_test_output_b_o <= 1'b0;
      lamp_a_status_o <= STAT_NORMAL;
      lamp_b_status_o <= STAT_NORMAL;
      in_status_o <= '0;
      out_status_o <= '0;
      test_status_o <= '0;
      in_combined_o <= STAT_FAULT;
      out_combined_o <= STAT_FAULT;
      out_monitor_o <= '0;
      supply_fault_o <= 1'b0;
      sensor_pwr_fault_o <= '0;
      signal_range_fault_o <= '0;
      wire_broken_o <= '0;
      meas_mismatch_o <= '0;
      ain_status_o <= '0;
      ain_value_o <= '0;
      alarm_status_o <= '0;
    end
    else
    begin
      lamp_test_output_a_o <= lamp_cmd[0]; // RQ11
      lamp_test_output_b_o <= lamp_cmd[1]; // RQ11
      lamp_a_status_o <= lamp_stat[0]; // RQ10
      lamp_b_status_o <= lamp_stat[1]; // RQ10
      in_status_o <= next_in_status;
      out_status_o <= next_out_status;
      test_status_o <= next_test_status;
      in_combined_o <= next_in_comb;
      out_combined_o <= next_out_comb;
      out_monitor_o <= out_actual_i; // RQ16
      supply_fault_o <= supply_range_fault_i; // RQ18
      sensor_pwr_fault_o <= sensor_pwr_fault_i; // RQ18
      signal_range_fault_o <= signal_range_fault_i; // RQ18
      wire_broken_o <= next_wire;
      meas_mismatch_o <= next_mis;
      ain_status_o <= next_ain_stat;
      ain_value_o <= next_ain_val;
      alarm_status_o <= alarm_raw_i; // RQ20
    end
  end

endmodule : ltsm_top

// >>> src/ltsm_pkg.sv
//------------------------------------------------------------------------------
// Purpose: shared constants for the lamp test and status monitor
// Assumes: 125 MHz reference clock
// Notes: times kept in their own units, cycle counts derived from them
//------------------------------------------------------------------------------
package ltsm_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam longint unsigned CLK_HZ = 64'd125_000_000;
  localparam int unsigned LAMP_INTERVAL_S = 3;
  localparam int unsigned LAMP_REPORT_MAX_S = 6;
  localparam longint unsigned LAMP_INTERVAL_CYC = CLK_HZ * LAMP_INTERVAL_S;
  localparam int unsigned LAMP_FAIL_LIMIT = 2;
  localparam int unsigned LAMP_FAIL_W = 2;

  // ----------------------------------------------------------------
  // status bit polarity
  // ----------------------------------------------------------------
  localparam logic STAT_NORMAL = 1'b1;
  localparam logic STAT_FAULT = 1'b0;

  // ----------------------------------------------------------------
  // alarm word layout per analog channel
  // ----------------------------------------------------------------
  localparam int unsigned ALM_HH = 0;
  localparam int unsigned ALM_LL = 1;
  localparam int unsigned ALM_HI = 2;
  localparam int unsigned ALM_LO = 3;
  localparam int unsigned ALM_DUAL_LOW = 4;
  localparam int unsigned ALM_TACH_OVR = 5;
  localparam int unsigned ALM_TACH_UND = 6;
  localparam int unsigned ALM_W = 7;

  // lamp checker states
  typedef enum logic [1:0]
  {
    LTSM_IDLE = 2'b00,
    LTSM_ARMED = 2'b01,
    LTSM_FAILED = 2'b10
  } ltsm_lamp_e;

endpackage : ltsm_pkg

// >>> src/ltsm_lamp_if.sv
//------------------------------------------------------------------------------
// Purpose: links the interval tick source to each lamp checker
// Assumes: single clock domain
// Notes: tick is a one-cycle pulse
//------------------------------------------------------------------------------
`timescale 1ns/1ps
interface ltsm_lamp_if;
  logic tick;
  logic cmd_on;
  logic lamp_ok;
  logic status;
  modport checker_side (input tick, input cmd_on, input lamp_ok, output status);
  modport top_side (output tick, output cmd_on, output lamp_ok, input status);
endinterface : ltsm_lamp_if

// >>> src/ltsm_lamp_check.sv
//------------------------------------------------------------------------------
// Purpose: one lamp open-circuit checker with two-strike declaration
// Assumes: tick marks each 3 s interval boundary
// Notes: status is registered
//------------------------------------------------------------------------------
`timescale 1ns/1ps
module ltsm_lamp_check
  import ltsm_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  ltsm_lamp_if.checker_side lamp
);

  ltsm_lamp_e state;
  ltsm_lamp_e next_state;
  logic [LAMP_FAIL_W-1:0] fails;
  logic [LAMP_FAIL_W-1:0] next_fails;
  logic status;
  logic next_status;

  // ----------------------------------------------------------------
  // next-state: tests only on a boundary after the output came on
  // ----------------------------------------------------------------
  always_comb
  begin
    next_state = state;
    next_fails = fails;
    next_status = status;
    case (state)
      LTSM_IDLE:
      begin
        next_fails = '0; // RQ21
        if (lamp.cmd_on)
          next_state = LTSM_ARMED; // RQ3
      end
      LTSM_ARMED, LTSM_FAILED:
      begin
        if (!lamp.cmd_on)
        begin
          next_state = LTSM_IDLE;
          next_fails = '0; // RQ21
        end
        else if (lamp.tick) // RQ1 RQ4
        begin
          if (lamp.lamp_ok)
            next_fails = '0; // RQ21
          else if (fails < LAMP_FAIL_W'(LAMP_FAIL_LIMIT))
            next_fails = fails + 1'b1;
          if (!lamp.lamp_ok && fails == LAMP_FAIL_W'(LAMP_FAIL_LIMIT - 1))
          begin
            next_state = LTSM_FAILED; // RQ2 RQ5
            next_status = STAT_FAULT; // RQ10
          end
        end
      end
      default:
        next_state = LTSM_IDLE;
    endcase
    // replaced lamp restores normal regardless of command
    if (status == STAT_FAULT && lamp.lamp_ok)
      next_status = STAT_NORMAL; // RQ9
  end

  // ----------------------------------------------------------------
  // registers: status starts normal, so an off output reads on
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      state <= LTSM_IDLE;
      fails <= '0;
      status <= STAT_NORMAL; // RQ7 RQ8
    end
    else
    begin
      state <= next_state;
      fails <= next_fails;
      status <= next_status;
    end
  end

  assign lamp.status = status;

endmodule : ltsm_lamp_check

// >>> verif/ltsm_assertions.sv
// Purpose: port assertions for the lamp test and status monitor
// Assumes: default widths, lamp a watched
// Notes: counters stand in for long windows
`timescale 1ns/1ps
module ltsm_assertions
  import ltsm_pkg::*;
#(
  parameter longint unsigned INTERVAL_CYC = 50
)
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic lamp_test_output_a_cmd_i,
  input wire logic lamp_a_sense_ok_i,
  input wire logic lamp_a_status_o,
  input wire logic [7:0] out_fault_i,
  input wire logic out_combined_o,
  input wire logic [7:0] out_actual_i,
  input wire logic [7:0] out_monitor_o,
  input wire logic [3:0] current_mode_i,
  input wire logic [3:0] wire_open_i,
  input wire logic [3:0] wire_broken_o,
  input wire logic [3:0] meas_mismatch_o,
  input wire logic [3:0] ain_status_o,
  input wire logic [3:0][15:0] ain_value_o,
  input wire logic [3:0][6:0] alarm_raw_i,
  input wire logic [3:0][6:0] alarm_status_o
);
  // ----------------------------------------------------------------
  // helper counters
  // ----------------------------------------------------------------
  localparam int DECL = 2 * int'(INTERVAL_CYC) + 10;
  logic [3:0] off_cnt;
  logic [15:0] bad_run;
  logic [4:0] ok_run;
  default clocking @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);
  // saturating, so a long quiet spell never wraps into a false match
  always_ff @(posedge ref_clk_i)
  begin
    off_cnt <= rst_i ? 4'hf : lamp_test_output_a_cmd_i ? 4'h0 : off_cnt + 4'(off_cnt != 4'hf);
    bad_run <= (rst_i || !lamp_test_output_a_cmd_i || lamp_a_sense_ok_i) ? 16'h0 :
      bad_run + 16'(bad_run != 16'hffff);
    ok_run <= (rst_i || !lamp_a_sense_ok_i) ? 5'h0 : ok_run + 5'(ok_run != 5'h1f);
  end
  a_out_comb: assert property (!$past(rst_i) |-> out_combined_o == ~|$past(out_fault_i))
    else $error("out_combined_o not the and of output statuses");
  a_out_monitor: assert property (!$past(rst_i) |-> out_monitor_o == $past(out_actual_i))
    else $error("out_monitor_o not the actual output state");
  a_wire_mode: assert property (!$past(rst_i) |->
    wire_broken_o == $past(wire_open_i & current_mode_i))
    else $error("wire_broken_o flagged outside current mode");
  a_mismatch_zero: assert property (meas_mismatch_o[0] |->
    ain_value_o[0] == 16'h0 && !ain_status_o[0])
    else $error("mismatched channel not zeroed and faulted");
  a_alarm_copy: assert property (!$past(rst_i) |-> alarm_status_o == $past(alarm_raw_i))
    else $error("alarm_status_o not the channel alarm flags");
  a_fall_cmd: assert property ($fell(lamp_a_status_o) |-> off_cnt < 4'h8)
    else $error("lamp status fell with the test output off");
  a_decl_bound: assert property (bad_run == DECL |-> !lamp_a_status_o)
    else $error("burned lamp not declared in two intervals");
  a_sense_restore: assert property (ok_run == 5'h10 |-> lamp_a_status_o)
    else $error("lamp status not restored after lamp replaced");
  c_declare: cover property ($fell(lamp_a_status_o));
  c_restore: cover property ($rose(lamp_a_status_o));
  c_mismatch: cover property (meas_mismatch_o[0]);
endmodule : ltsm_assertions
bind ltsm_top ltsm_assertions #(.INTERVAL_CYC(INTERVAL_CYC)) u_chk (.ref_clk_i, .rst_i,
  .lamp_test_output_a_cmd_i, .lamp_a_sense_ok_i, .lamp_a_status_o, .out_fault_i,
  .out_combined_o, .out_actual_i, .out_monitor_o, .current_mode_i, .wire_open_i,
  .wire_broken_o, .meas_mismatch_o, .ain_status_o, .ain_value_o, .alarm_raw_i,
  .alarm_status_o);

// >>> verif/ltsm_ctrl_model.sv
// Purpose: controller program driving one lamp test output
// Assumes: req_i asks for the lamp, link_i is the connection
// Notes: on time stretched to a minimum
`timescale 1ns/1ps
module ltsm_ctrl_model
#(
  parameter int MIN_ON = 120
)
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic req_i,
  input wire logic link_i,
  input wire logic status_i,
  output logic cmd_o,
  output logic copy_o
);
  // ----------------------------------------------------------------
  // lamp command and status copy
  // ----------------------------------------------------------------
  logic [15:0] hold;
  // a short request still gets two full test intervals
  always_ff @(posedge ref_clk_i)
    hold <= rst_i ? 16'h0 : req_i ? 16'(MIN_ON) : hold - 16'(hold != 16'h0);
  // the program alone commands, the status bit never feeds back
  assign cmd_o = req_i || hold != 16'h0;
  // a lost connection reads as all off
  assign copy_o = link_i && status_i;
endmodule : ltsm_ctrl_model

// >>> verif/testbench.sv
// Purpose: self-checking bench for the lamp test and status monitor
// Assumes: interval shortened to IV cycles
// Notes: lamp a via the controller model, lamp b driven directly
`timescale 1ns/1ps
module testbench
  import ltsm_pkg::*;
;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  localparam int IV = 50;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic req = 1'b0;
  logic link = 1'b1;
  logic lamp_test_output_b_cmd_i = 1'b0;
  logic lamp_a_sense_ok_i = 1'b0;
  logic lamp_b_sense_ok_i = 1'b0;
  logic supply_range_fault_i = 1'b0;
  logic [7:0] in_fault_i = 8'h0, out_fault_i = 8'h0, out_actual_i = 8'h0;
  logic [3:0] test_fault_i = 4'h0, sensor_pwr_fault_i = 4'h0, signal_range_fault_i = 4'h0;
  logic [3:0] current_mode_i = 4'h0, wire_open_i = 4'h0;
  logic [3:0][15:0] meas_a_i = '0, meas_b_i = '0, ain_value_o;
  logic [15:0] meas_tol_i = 16'h2;
  logic [3:0][6:0] alarm_raw_i = '0, alarm_status_o;
  logic lamp_test_output_a_cmd_i, lamp_test_output_a_o, lamp_test_output_b_o, copy;
  logic lamp_a_status_o, lamp_b_status_o, in_combined_o, out_combined_o, supply_fault_o;
  logic [7:0] in_status_o, out_status_o, out_monitor_o;
  logic [3:0] test_status_o, sensor_pwr_fault_o, signal_range_fault_o, wire_broken_o;
  logic [3:0] meas_mismatch_o, ain_status_o;
  int num_checks = 0;
  int n_mismatch = 0;
  int cyc = 0;
  always #4 ref_clk_i = ~ref_clk_i;
  ltsm_ctrl_model #(.MIN_ON(2 * IV + 20)) i_ctrl (.ref_clk_i, .rst_i, .req_i(req),
    .link_i(link), .status_i(lamp_a_status_o), .cmd_o(lamp_test_output_a_cmd_i),
    .copy_o(copy));
  ltsm_top #(.INTERVAL_CYC(IV)) i_dut (.ref_clk_i, .rst_i, .lamp_test_output_a_cmd_i,
    .lamp_test_output_b_cmd_i, .lamp_a_sense_ok_i, .lamp_b_sense_ok_i, .lamp_test_output_a_o,
    .lamp_test_output_b_o, .lamp_a_status_o, .lamp_b_status_o, .in_fault_i, .out_fault_i,
    .test_fault_i, .out_actual_i, .in_status_o, .out_status_o, .test_status_o, .in_combined_o,
    .out_combined_o, .out_monitor_o, .supply_range_fault_i, .sensor_pwr_fault_i,
    .signal_range_fault_i, .current_mode_i, .wire_open_i, .meas_a_i, .meas_b_i, .meas_tol_i,
    .alarm_raw_i, .supply_fault_o, .sensor_pwr_fault_o, .signal_range_fault_o, .wire_broken_o,
    .meas_mismatch_o, .ain_status_o, .ain_value_o, .alarm_status_o);
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  // sample just past the edge so its updates have landed
  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask : wt
  task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
    num_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : stop_test
  task automatic t_lamp_a;
    wt(3 * IV);
    chk("a_stat", STAT_NORMAL, lamp_a_status_o);
    chk("b_stat", STAT_NORMAL, lamp_b_status_o);
    @(posedge ref_clk_i);
    req <= 1'b1;
    @(posedge ref_clk_i);
    req <= 1'b0;
    wt(IV - 1);
    chk("a_stat", STAT_NORMAL, lamp_a_status_o);
    chk("a_out", 1'b1, lamp_test_output_a_o);
    // open lamp from power-up must show within two intervals
    for (int i = 0; i < IV + 12 && lamp_a_status_o !== STAT_FAULT; i++)
      wt(1);
    chk("a_stat", STAT_FAULT, lamp_a_status_o);
    wt(2 * IV);
    chk("a_out", 1'b0, lamp_test_output_a_o);
    chk("a_stat", STAT_FAULT, lamp_a_status_o);
    @(posedge ref_clk_i);
    lamp_a_sense_ok_i <= 1'b1;
    wt(16);
    chk("a_stat", STAT_NORMAL, lamp_a_status_o);
    $display("t_lamp_a done");
  endtask : t_lamp_a
  task automatic t_lamp_b;
    // windows too short for two ticks, off clears the strike
    repeat (4)
    begin
      @(posedge ref_clk_i);
      lamp_test_output_b_cmd_i <= 1'b1;
      wt(30);
      @(posedge ref_clk_i);
      lamp_test_output_b_cmd_i <= 1'b0;
      wt(5);
    end
    chk("b_stat", STAT_NORMAL, lamp_b_status_o);
    @(posedge ref_clk_i);
    lamp_test_output_b_cmd_i <= 1'b1;
    wt(2 * IV + 12);
    chk("b_out", 1'b1, lamp_test_output_b_o);
    chk("b_stat", STAT_FAULT, lamp_b_status_o);
    @(posedge ref_clk_i);
    lamp_b_sense_ok_i <= 1'b1;
    wt(16);
    chk("b_stat", STAT_NORMAL, lamp_b_status_o);
    @(posedge ref_clk_i);
    lamp_test_output_b_cmd_i <= 1'b0;
    link <= 1'b0;
    wt(1);
    chk("copy", 1'b0, copy);
    chk("b_out", 1'b0, lamp_test_output_b_o);
    $display("t_lamp_b done");
  endtask : t_lamp_b
  task automatic t_points(input int k);
    logic [3:0] mm;
    logic [3:0] cf;
    logic [3:0][15:0] ev;
    logic [15:0] d;
    @(posedge ref_clk_i);
    in_fault_i <= k == 1 ? 8'h10 : 8'h00;
    out_fault_i <= k == 1 ? 8'h01 : 8'h00;
    test_fault_i <= k == 1 ? 4'h2 : 4'h0;
    out_actual_i <= k == 1 ? 8'h5a : 8'ha5;
    supply_range_fault_i <= k == 2;
    sensor_pwr_fault_i <= k == 1 ? 4'h2 : 4'h0;
    signal_range_fault_i <= k == 2 ? 4'h8 : 4'h0;
    current_mode_i <= k == 1 ? 4'h6 : 4'h9;
    wire_open_i <= k == 1 ? 4'hc : 4'h0;
    meas_a_i <= {16'h0400, 16'h0300, 16'h0202, 16'h0105};
    meas_b_i <= k == 1 ? {16'h0400, 16'h0300, 16'h0200, 16'h0102} :
      {16'h0400, 16'h0304, 16'h0204, 16'h0105};
    alarm_raw_i <= k == 1 ? 28'hfedcba9 : 28'h0123456;
    wt(2);
    for (int c = 0; c < 4; c++)
    begin
      d = meas_a_i[c] > meas_b_i[c] ? meas_a_i[c] - meas_b_i[c] : meas_b_i[c] - meas_a_i[c];
      mm[c] = d > meas_tol_i;
      ev[c] = mm[c] ? 16'h0 : meas_a_i[c];
    end
    cf = sensor_pwr_fault_i | signal_range_fault_i | (wire_open_i & current_mode_i) | mm;
    chk("in_st", 8'(~in_fault_i), in_status_o);
    chk("out_st", 8'(~out_fault_i), out_status_o);
    chk("test_st", 4'(~test_fault_i), test_status_o);
    chk("in_comb", ~|in_fault_i, in_combined_o);
    chk("out_comb", ~|out_fault_i, out_combined_o);
    chk("monitor", out_actual_i, out_monitor_o);
    chk("supply", supply_range_fault_i, supply_fault_o);
    chk("pwr", sensor_pwr_fault_i, sensor_pwr_fault_o);
    chk("range", signal_range_fault_i, signal_range_fault_o);
    chk("wire", wire_open_i & current_mode_i, wire_broken_o);
    chk("mismatch", mm, meas_mismatch_o);
    chk("ain_st", 4'(~(cf | {4{supply_range_fault_i}})), ain_status_o);
    chk("ain_val", ev, ain_value_o);
    chk("alarm", alarm_raw_i, alarm_status_o);
    $display("t_points %0d done", k);
  endtask : t_points
  // ----------------------------------------------------------------
  // run
  // ----------------------------------------------------------------
  // the run needs about 680 cycles, well under the 3000-cycle limit that cuts a hang
  always @(posedge ref_clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      n_mismatch++;
      stop_test();
    end
  end
  initial
  begin
    repeat (16) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    t_lamp_a();
    t_lamp_b();
    t_points(0);
    t_points(1);
    t_points(2);
    stop_test();
  end
endmodule : testbench
